// ==== design/efs_gearing.sv ====
// Purpose: Encoder-following motion with stall, lag and current control.
// Assumes: APB slave, zero wait states; external moves report their steps.
// Notes:   Position error compares motor steps with encoder counts directly.
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "efs_defines.svh"
module efs_gearing #(
  parameter int STILL_CYCLES = `EFS_STILL_CYC
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        enc_a,
  input  wire logic        enc_b,
  input  wire logic [4:0]  aux_pins,
  input  wire logic        move_step,
  input  wire logic        move_cw,
  output logic             step_out,
  output logic             dir_cw,
  output logic             move_abort,
  output logic             moving,
  output logic             hybrid_active,
  output logic      [6:0]  current_pct,
  output logic      [5:0]  loop_gain
);
  efs_enc_if enc ();
  efs_pin_front u_front (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .enc_a    (enc_a),
    .enc_b    (enc_b),
    .aux_pins (aux_pins),
    .port     (enc.src)
  );

  efs_pkg::efs_state_t state_q;
  efs_pkg::efs_state_t state_d;
  logic        [7:0]  ctrl_q;
  logic        [7:0]  num_q;
  logic        [7:0]  den_q;
  logic        [14:0] spt_q;
  logic        [15:0] ept_q;
  logic        [6:0]  idle_q;
  logic        [5:0]  gain_q;
  logic        [5:0]  incfg_q;
  logic               cfg_err_q;
  logic               stall_err_q;
  logic               lag_q;
  logic               hyb_q;
  logic        [4:0]  aux_prev_q;
  logic signed [23:0] enc_pos_q;
  logic signed [23:0] cap_pos_q;
  logic signed [23:0] mot_pos_q;
  logic signed [31:0] rem_q;
  logic signed [15:0] pend_q;
  logic        [10:0] per_q;
  logic        [10:0] tmr_q;
  logic        [17:0] still_q;
  logic        [31:0] rdata_q;

  logic               wr;
  logic               follow;
  logic               manual;
  logic               halt_req;
  logic               stall_trip;
  logic               step_now;
  logic               cap_hit;
  logic               estop_hit;
  logic signed [31:0] thr;
  logic signed [31:0] add;
  logic signed [31:0] sub;
  logic        [1:0]  gen;
  logic signed [24:0] pos_err;
  logic        [24:0] err_abs;

  function automatic logic in_rng(input logic [15:0] v, input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_rng = (v >= lo) && (v <= hi);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= `EFS_OFF_MOTPOS);
  endfunction

  assign wr       = psel && penable && pwrite;
  assign manual   = ctrl_q[`EFS_B_CW] || ctrl_q[`EFS_B_CCW];
  assign follow   = (state_q == efs_pkg::EFS_RUN) && manual; // R06
  assign pready   = psel && penable;
  assign pslverr  = psel && penable && !mapped(paddr);
  assign prdata   = rdata_q;

  // APB read data is taken in the setup cycle so it is stable in the access cycle.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `EFS_OFF_CTRL:   rdata_q <= {24'h00_0000, 1'b0, hyb_q, ctrl_q[5:0]};
        `EFS_OFF_GEAR:   rdata_q <= {16'h0000, den_q, num_q};
        `EFS_OFF_SPT:    rdata_q <= {17'h0_0000, spt_q};
        `EFS_OFF_EPT:    rdata_q <= {16'h0000, ept_q};
        `EFS_OFF_CURR:   rdata_q <= {18'h0_0000, gain_q, 1'b0, idle_q};
        `EFS_OFF_INCFG:  rdata_q <= {26'h000_0000, incfg_q};
        `EFS_OFF_STATUS: rdata_q <= {26'h000_0000, state_q, lag_q, stall_err_q,
                                     cfg_err_q, moving};
        `EFS_OFF_ENCPOS: rdata_q <= {{8{enc_pos_q[23]}}, enc_pos_q};
        `EFS_OFF_CAPPOS: rdata_q <= {{8{cap_pos_q[23]}}, cap_pos_q};
        `EFS_OFF_MOTPOS: rdata_q <= {{8{mot_pos_q[23]}}, mot_pos_q};
        default:         rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Control word; the hold bit is stored but never acted on by gearing.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= 8'h00;
    end else if (wr && paddr == `EFS_OFF_CTRL) begin
      ctrl_q[3:0] <= pwdata[3:0]; // R11
      if (!(pwdata[`EFS_B_GEAR] && pwdata[`EFS_B_STALL])) begin
        ctrl_q[5:4] <= pwdata[5:4]; // R15
      end
    end
  end

  // Hybrid goes off only at rest, and on only with a move start.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hyb_q <= 1'b0;
    end else if (wr && paddr == `EFS_OFF_CTRL) begin
      if (!pwdata[`EFS_B_HYB] && !moving) begin
        hyb_q <= 1'b0; // R21
      end else if (pwdata[`EFS_B_HYB] && (pwdata[`EFS_B_CW] || pwdata[`EFS_B_CCW])) begin
        hyb_q <= 1'b1; // R21
      end
    end
  end

  // Parameter registers keep their old value when a write is out of range.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      num_q   <= `EFS_RST_RATIO;
      den_q   <= `EFS_RST_RATIO;
      spt_q   <= `EFS_RST_SPT;
      ept_q   <= `EFS_RST_EPT;
      idle_q  <= `EFS_RST_IDLE;
      gain_q  <= `EFS_RST_GAIN;
      incfg_q <= 6'h00;
    end else if (wr) begin
      case (paddr)
        `EFS_OFF_GEAR: begin
          if (pwdata[7:0] != 8'h00 && pwdata[15:8] != 8'h00) begin
            num_q <= pwdata[7:0]; // R03 R04
            den_q <= pwdata[15:8]; // R03 R04
          end
        end
        `EFS_OFF_SPT: begin
          if (!moving && in_rng(pwdata[15:0], {1'b0, `EFS_SPT_MIN}, {1'b0, `EFS_SPT_MAX})) begin
            spt_q <= pwdata[14:0]; // R01 R02
          end
        end
        `EFS_OFF_EPT: ept_q <= pwdata[15:0]; // R16
        `EFS_OFF_CURR: begin
          if (pwdata[6:0] <= `EFS_IDLE_MAX && pwdata[7] == 1'b0) begin
            idle_q <= pwdata[6:0]; // R22
          end
          if (in_rng({10'h000, pwdata[13:8]}, {10'h000, `EFS_GAIN_MIN},
                     {10'h000, `EFS_GAIN_MAX}) && pwdata[15:14] == 2'b00) begin
            gain_q <= pwdata[13:8]; // R23
          end
        end
        `EFS_OFF_INCFG: incfg_q <= pwdata[5:0];
        default: ;
      endcase
    end
  end

  // Sticky configuration error; a new refusal wins over the clear bit.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_err_q <= 1'b0;
    end else if (wr && (
        (paddr == `EFS_OFF_CTRL && pwdata[`EFS_B_GEAR] && pwdata[`EFS_B_STALL]) ||
        (paddr == `EFS_OFF_GEAR && (pwdata[7:0] == 8'h00 || pwdata[15:8] == 8'h00)) ||
        (paddr == `EFS_OFF_SPT && (moving || !in_rng(pwdata[15:0],
          {1'b0, `EFS_SPT_MIN}, {1'b0, `EFS_SPT_MAX}))) ||
        (paddr == `EFS_OFF_CURR && (pwdata[7:0] > {1'b0, `EFS_IDLE_MAX} ||
          !in_rng({8'h00, pwdata[15:8]}, {10'h000, `EFS_GAIN_MIN},
                  {10'h000, `EFS_GAIN_MAX}))))) begin
      cfg_err_q <= 1'b1; // R01 R02 R03 R15 R22 R23
    end else if (wr && paddr == `EFS_OFF_CTRL && pwdata[`EFS_B_CLRERR]) begin
      cfg_err_q <= 1'b0;
    end
  end

  // Stall trip at one eighth of a turn of lag; lag flag at a full turn.
  assign pos_err = {mot_pos_q[23], mot_pos_q} - {enc_pos_q[23], enc_pos_q};
  assign err_abs = pos_err[24] ? 25'(-pos_err) : 25'(pos_err);
  assign stall_trip = ctrl_q[`EFS_B_STALL] && !ctrl_q[`EFS_B_GEAR] &&
                      err_abs > {12'h000, ept_q[15:3]}; // R14 R19

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stall_err_q <= 1'b0;
    end else if (stall_trip) begin
      stall_err_q <= 1'b1; // R14 R19
    end else if (wr && paddr == `EFS_OFF_CTRL && pwdata[`EFS_B_CLRERR]) begin
      stall_err_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lag_q <= 1'b0;
    end else begin
      lag_q <= hyb_q && !ctrl_q[`EFS_B_STALL] && err_abs > {9'h000, ept_q}; // R18 R20
    end
  end

  // Discrete input roles: capture and emergency stop act on rising edges.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      aux_prev_q <= 5'h00;
    end else begin
      aux_prev_q <= enc.aux;
    end
  end

  always_comb begin
    cap_hit   = 1'b0;
    estop_hit = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (enc.aux[i] && !aux_prev_q[i]) begin
        if (incfg_q[2*i +: 2] == efs_pkg::EFS_IN_CAPTURE) begin
          cap_hit = 1'b1;
        end
        if (incfg_q[2*i +: 2] == efs_pkg::EFS_IN_ESTOP) begin
          estop_hit = 1'b1;
        end
      end
    end
  end

  assign halt_req = (wr && paddr == `EFS_OFF_CTRL && pwdata[`EFS_B_ISTOP] &&
                     !ctrl_q[`EFS_B_ISTOP]) || estop_hit ||
                    (enc.aux[3] || enc.aux[4]) || stall_trip; // R12 R14

  always_comb begin
    state_d = state_q;
    case (state_q)
      efs_pkg::EFS_IDLE: if (ctrl_q[`EFS_B_GEAR] && manual) state_d = efs_pkg::EFS_RUN;
      efs_pkg::EFS_RUN:  if (!manual || !ctrl_q[`EFS_B_GEAR]) state_d = efs_pkg::EFS_STOP; // R10
      efs_pkg::EFS_STOP: if (pend_q == 16'sh0000) state_d = efs_pkg::EFS_IDLE; // R10
      efs_pkg::EFS_HALT: if (!manual && !stall_err_q) state_d = efs_pkg::EFS_IDLE;
      default:           state_d = efs_pkg::EFS_IDLE;
    endcase
    if (halt_req) begin
      state_d = efs_pkg::EFS_HALT; // R12
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= efs_pkg::EFS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      enc_pos_q <= 24'sh00_0000;
    end else if (enc.inc) begin
      enc_pos_q <= enc_pos_q + 24'sh00_0001; // R05
    end else if (enc.dec) begin
      enc_pos_q <= enc_pos_q - 24'sh00_0001; // R05
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cap_pos_q <= 24'sh00_0000;
    end else if (cap_hit && ctrl_q[`EFS_B_GEAR]) begin
      cap_pos_q <= enc_pos_q; // R09
    end
  end

  // Scaling: each count adds numerator times motor resolution; one step costs
  // denominator times steps-per-turn, and what is left over stays in rem_q.
  assign thr = {24'h00_0000, den_q} * {17'h0_0000, spt_q}; // R03
  assign add = !follow ? 32'sh0 :
               enc.inc ? 32'(num_q * `EFS_MOTOR_RES) :
               enc.dec ? -32'(num_q * `EFS_MOTOR_RES) : 32'sh0; // R03 R06
  assign gen = (rem_q >= thr) ? 2'b01 : (rem_q <= -thr) ? 2'b10 : 2'b00;
  assign sub = gen[0] ? thr : gen[1] ? -thr : 32'sh0;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rem_q <= 32'sh0;
    end else if (state_q == efs_pkg::EFS_HALT) begin
      rem_q <= 32'sh0;
    end else begin
      rem_q <= rem_q + add - sub; // R24
    end
  end

  assign step_now = (pend_q != 16'sh0000) && (tmr_q >= per_q) &&
                    (state_q != efs_pkg::EFS_HALT);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pend_q <= 16'sh0000;
    end else if (state_q == efs_pkg::EFS_HALT) begin
      pend_q <= 16'sh0000; // R12
    end else begin
      pend_q <= pend_q + (gen[0] ? 16'sh0001 : gen[1] ? -16'sh0001 : 16'sh0000)
                - (!step_now ? 16'sh0000 : pend_q[15] ? -16'sh0001 : 16'sh0001);
    end
  end

  // Idle timer sits at the slowest period so the first step leaves at once.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tmr_q <= 11'(`EFS_PER_MAX);
    end else if (step_now) begin
      tmr_q <= 11'h000;
    end else if (tmr_q < 11'(`EFS_PER_MAX)) begin
      tmr_q <= tmr_q + 11'h001; // R07
    end
  end

  // Step period ramps one cycle per step, so ratio changes speed up or slow down.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      per_q <= 11'(`EFS_PER_MAX);
    end else if (pend_q == 16'sh0000) begin
      per_q <= 11'(`EFS_PER_MAX);
    end else if (step_now) begin
      if ((pend_q > 16'sh0001 || pend_q < -16'sh0001) && per_q > `EFS_PER_MIN) begin
        per_q <= per_q - 11'h001; // R04
      end else if (pend_q <= 16'sh0001 && pend_q >= -16'sh0001 &&
                   per_q < 11'(`EFS_PER_MAX)) begin
        per_q <= per_q + 11'h001; // R04
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      step_out <= 1'b0;
      dir_cw   <= 1'b1;
    end else begin
      step_out <= step_now;
      if (step_now) begin
        dir_cw <= !pend_q[15]; // R08
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mot_pos_q <= 24'sh00_0000;
    end else if (step_now) begin
      mot_pos_q <= pend_q[15] ? mot_pos_q - 24'sh00_0001 : mot_pos_q + 24'sh00_0001;
    end else if (move_step) begin
      mot_pos_q <= move_cw ? mot_pos_q + 24'sh00_0001 : mot_pos_q - 24'sh00_0001;
    end
  end

  // Encoder at rest for the still time ends motion once steps drain.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      still_q <= 18'h0_0000;
    end else if (enc.inc || enc.dec || move_step) begin
      still_q <= 18'h0_0000;
    end else if (still_q < 18'(STILL_CYCLES)) begin
      still_q <= still_q + 18'h0_0001; // R10
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      moving        <= 1'b0;
      move_abort    <= 1'b0;
      hybrid_active <= 1'b0;
      current_pct   <= `EFS_RST_IDLE;
      loop_gain     <= `EFS_RST_GAIN;
    end else begin
      moving        <= (pend_q != 16'sh0000) || (still_q < 18'(STILL_CYCLES)); // R10
      move_abort    <= state_q == efs_pkg::EFS_HALT; // R14
      hybrid_active <= hyb_q;
      current_pct   <= moving ? `EFS_IDLE_MAX : idle_q; // R22
      loop_gain     <= gain_q; // R23
    end
  end
endmodule
`default_nettype wire

// ==== design/efs_defines.svh ====
// Purpose: Constants of the encoder-following stepper block.
// Assumes: 25 MHz clock; APB byte addresses.
// Notes:   Offsets, fields, reset values, limits and timing counts.
// Summary of operation
// R01: Steps-per-turn accepts only 200 to 32767.
// R02: Steps-per-turn cannot change while a move runs.
// R03: Steps equal counts times numerator over denominator; each 1 to 255.
// R04: Ratio may change during gearing; motor ramps to new ratio.
// R05: Encoder decoded 4X, every edge of both channels counts.
// R06: Gearing follows encoder only while a manual-move bit is set.
// R07: Steps start within 50 us after an encoder change.
// R08: Rising counts step clockwise, falling counts counter-clockwise.
// R09: Capture input latches encoder position while gearing.
// R10: Controlled stop when encoder stops or both manual bits clear.
// R11: Hold bit is ignored for gearing moves.
// R12: Immediate stop on stop-bit rise, e-stop rise or limit switch.
// R13: Index pulse never corrects the encoder position.
// R14: Stall detection ends a move whose encoder does not follow; error set.
// R15: Stall detection and gearing are never enabled together.
// R16: Host sets encoder counts per turn to four times line count.
// R17: Hybrid needs steps-per-turn equal to encoder counts per turn.
// R18: Hybrid sets lag bit while error exceeds 360 degrees; move continues.
// R19: Stall with hybrid trips at lag over 45 degrees; move ends, error set.
// R20: Lag bit never set while stall detection is enabled.
// R21: Hybrid switched off at rest by one command, on by next move start.
// R22: Idle current is 0 to 100 percent of running current.
// R23: Current loop gain accepts 1 to 40.
// R24: Fractional remainder of scaled counts is carried between updates.
`ifndef EFS_DEFINES_SVH
`define EFS_DEFINES_SVH
`define EFS_OFF_CTRL     8'h00
`define EFS_OFF_GEAR     8'h04
`define EFS_OFF_SPT      8'h08
`define EFS_OFF_EPT      8'h0c
`define EFS_OFF_CURR     8'h10
`define EFS_OFF_INCFG    8'h14
`define EFS_OFF_STATUS   8'h18
`define EFS_OFF_ENCPOS   8'h1c
`define EFS_OFF_CAPPOS   8'h20
`define EFS_OFF_MOTPOS   8'h24
`define EFS_B_CW         0
`define EFS_B_CCW        1
`define EFS_B_HOLD       2
`define EFS_B_ISTOP      3
`define EFS_B_GEAR       4
`define EFS_B_STALL      5
`define EFS_B_HYB        6
`define EFS_B_CLRERR     7
`define EFS_SPT_MIN      15'h00c8
`define EFS_SPT_MAX      15'h7fff
`define EFS_RATIO_MIN    8'h01
`define EFS_RATIO_MAX    8'hff
`define EFS_IDLE_MAX     7'h64
`define EFS_GAIN_MIN     6'h01
`define EFS_GAIN_MAX     6'h28
`define EFS_RST_SPT      15'h00c8
`define EFS_RST_EPT      16'h0fa0
`define EFS_RST_RATIO    8'h01
`define EFS_RST_IDLE     7'h32
`define EFS_RST_GAIN     6'h05
`define EFS_MOTOR_RES    17'h000c8
`define EFS_CLK_NS       40
`define EFS_START_NS     50000
`define EFS_PER_MAX      (`EFS_START_NS / `EFS_CLK_NS)
`define EFS_PER_MIN      11'h004
`define EFS_STILL_NS     10000000
`define EFS_STILL_CYC    (`EFS_STILL_NS / `EFS_CLK_NS)
`endif

// ==== design/efs_pkg.sv ====
// Purpose: Types of the encoder-following stepper block.
// Assumes: Constants live in efs_defines.svh.
// Notes:   Motion states use Gray codes; STOP to IDLE and RUN to HALT change both bits.
package efs_pkg;
  typedef enum logic [1:0] {
    EFS_IDLE = 2'b00,
    EFS_RUN  = 2'b01,
    EFS_STOP = 2'b11,
    EFS_HALT = 2'b10
  } efs_state_t;
  typedef enum logic [1:0] {
    EFS_IN_NONE    = 2'b00,
    EFS_IN_CAPTURE = 2'b01,
    EFS_IN_ESTOP   = 2'b10
  } efs_in_role_t;
endpackage

// ==== design/efs_enc_if.sv ====
// Purpose: Carries decoded encoder events and filtered pins.
// Assumes: Source and sink share one clock.
// Notes:   aux holds three discrete inputs, then CW and CCW limits.
`timescale 1ns/1ps
`default_nettype none
interface efs_enc_if;
  logic       inc;
  logic       dec;
  logic [4:0] aux;
  modport src (output inc, output dec, output aux);
  modport dst (input inc, input dec, input aux);
endinterface
`default_nettype wire

// ==== design/efs_pin_front.sv ====
// Purpose: Synchronises encoder and discrete pins and decodes quadrature.
// Assumes: Pins are asynchronous to clock.
// Notes:   A pin change counts once the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module efs_pin_front (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       enc_a,
  input  wire logic       enc_b,
  input  wire logic [4:0] aux_pins,
  efs_enc_if.src          port
);
  logic [6:0] s1_q;
  logic [6:0] s2_q;
  logic [6:0] s3_q;
  logic [6:0] stb_q;
  logic [1:0] ab_prev_q;

  // Returns 01 for a forward edge and 10 for a backward edge.
  function automatic logic [1:0] quad_step(input logic [1:0] o, input logic [1:0] n);
    case ({o, n})
      4'b0001, 4'b0111, 4'b1110, 4'b1000: quad_step = 2'b01;
      4'b0010, 4'b1011, 4'b1101, 4'b0100: quad_step = 2'b10;
      default: quad_step = 2'b00;
    endcase
  endfunction

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= 7'h00;
      s2_q <= 7'h00;
      s3_q <= 7'h00;
    end else begin
      s1_q <= {aux_pins, enc_a, enc_b};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stb_q <= 7'h00;
    end else begin
      for (int i = 0; i < 7; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          stb_q[i] <= s3_q[i];
        end
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ab_prev_q <= 2'b00;
    end else begin
      ab_prev_q <= stb_q[1:0];
    end
  end

  // Every edge of both channels yields one count; the index pulse is not an input.
  assign port.inc = quad_step(ab_prev_q, stb_q[1:0]) == 2'b01; // R05 R13
  assign port.dec = quad_step(ab_prev_q, stb_q[1:0]) == 2'b10; // R05
  assign port.aux = stb_q[6:2];
endmodule
`default_nettype wire

// ==== tb/efs_enc_model.sv ====
// Purpose: Quadrature encoder that drives the gearing block.
// Assumes: Channel B leads A on rising counts.
// Notes:   One pin edge per count, 12 clocks apart.
`timescale 1ns/1ps
`default_nettype none
module efs_enc_model (
  input  wire logic clock,
  output logic      enc_a,
  output logic      enc_b
);
  logic [1:0] ph = 2'b00;
  assign enc_a = ph[1];
  assign enc_b = ph[1] ^ ph[0];
  task automatic turn(input int n);
    repeat (n < 0 ? -n : n) begin
      repeat (12) @(posedge clock);
      ph <= (n < 0) ? ph - 2'h1 : ph + 2'h1;
    end
  endtask
endmodule
`default_nettype wire

// ==== tb/efs_gearing_assertions.sv ====
// Purpose: Port checks for the gearing block.
// Assumes: One clock, reset active high.
// Notes:   Bound from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module efs_gearing_assertions (
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic [4:0] aux_pins,
  input wire logic       step_out,
  input wire logic       dir_cw,
  input wire logic       move_abort,
  input wire logic       moving,
  input wire logic       hybrid_active,
  input wire logic [6:0] current_pct,
  input wire logic [5:0] loop_gain
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence lim_hit;
    $rose(aux_pins[3]) ##1 aux_pins[3] [*5];
  endsequence
  sequence run2;
    moving [*2];
  endsequence
  AST_LIMIT_HALT: assert property (lim_hit |-> ##[0:2] move_abort)
    else $error("limit no halt");
  AST_HALT_QUIET: assert property (move_abort [*2] |-> !step_out)
    else $error("step in halt");
  AST_STEP_GAP: assert property (step_out |=> !step_out [*3])
    else $error("steps too close");
  AST_DIR_STEP: assert property ($changed(dir_cw) |-> step_out)
    else $error("dir without step");
  AST_RUN_CURR: assert property (run2 |-> current_pct == 7'h64)
    else $error("run current");
  AST_IDLE_MAX: assert property (current_pct <= 7'h64)
    else $error("current high");
  AST_GAIN_RANGE: assert property (loop_gain inside {[6'h01:6'h28]})
    else $error("gain range");
  AST_HYB_REST: assert property ($fell(hybrid_active) |-> !$past(moving))
    else $error("hybrid off moving");
endmodule
`default_nettype wire

// ==== tb/efs_gearing_tb.sv ====
// Purpose: Self-checking bench for the gearing block.
// Assumes: Zero-wait APB; quiet time cut to 50 clocks.
// Notes:   At 200 steps per turn, steps = counts * num / den.
`timescale 1ns/1ps
`default_nettype none
module efs_gearing_tb;
  logic        clock, sys_rst, psel, penable, pwrite, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, enc_a, enc_b, step_out, dir_cw, move_abort;
  logic        moving, hybrid_active, move_step, move_cw;
  logic [4:0]  aux_pins;
  logic [6:0]  current_pct;
  logic [5:0]  loop_gain;
  int          miscompares, checks_done, steps, cycles, t;
  int          num[5] = '{1, 1, 1, 3, 1};
  int          den[5] = '{1, 2, 2, 2, 1};
  int          cnt[5] = '{4, 3, 3, 2, -4};
  int          exs[5] = '{4, 1, 2, 3, -4};
  efs_gearing #(.STILL_CYCLES(50)) dut_u (.clock, .sys_rst, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .enc_a, .enc_b, .aux_pins,
    .move_step, .move_cw, .step_out, .dir_cw, .move_abort, .moving,
    .hybrid_active, .current_pct, .loop_gain);
  efs_enc_model enc_u (.clock, .enc_a, .enc_b);
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Signed step count; also cuts a hang short.
  always @(posedge clock) begin
    cycles++;
    if (step_out === 1'b1) steps += (dir_cw === 1'b1) ? 1 : -1;
    if (cycles == 99000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check($sformatf("reg %h", a), rd, exp);
  endtask
  task automatic follow(input int n, input int exp);
    steps = 0;
    enc_u.turn(n);
    for (t = 0; t < 20000 && steps != exp; t++) @(posedge clock);
    repeat (1300) @(posedge clock);
    check("steps", steps, exp);
  endtask
  task automatic conclude();
    $display("miscompares %0d checks_done %0d", miscompares, checks_done);
    if (miscompares == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    sys_rst  = 1'b1;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h0;
    aux_pins = 5'h00;
    move_step = 1'b0;
    move_cw = 1'b1;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    bus(1'b1, 8'h08, 32'h300);
    rdchk(8'h08, 32'hc8);
    rdchk(8'h04, 32'h101);
    rdchk(8'h10, 32'h532);
    repeat (60) @(posedge clock);
    bus(1'b1, 8'h08, 32'hc7);
    rdchk(8'h08, 32'hc8);
    bus(1'b1, 8'h08, 32'h7fff);
    rdchk(8'h08, 32'h7fff);
    bus(1'b1, 8'h08, 32'hc8);
    bus(1'b1, 8'h04, 32'h100);
    rdchk(8'h04, 32'h101);
    bus(1'b1, 8'h10, 32'h2965);
    rdchk(8'h10, 32'h532);
    bus(1'b1, 8'h10, 32'h2819);
    bus(1'b0, 8'h18, 32'h0);
    check("cfg_err", rd[1], 1'b1);
    check("idle current", current_pct, 7'h19);
    check("gain", loop_gain, 6'h28);
    bus(1'b0, 8'h28, 32'h0);
    check("pslverr", err, 1'b1);
    bus(1'b1, 8'h00, 32'h10);
    follow(4, 0);
    bus(1'b1, 8'h00, 32'h15);
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, 8'h04, {16'h0, den[i][7:0], num[i][7:0]});
      follow(cnt[i], exs[i]);
    end
    rdchk(8'h1c, 32'hc);
    rdchk(8'h24, 32'h6);
    bus(1'b1, 8'h14, 32'h1);
    aux_pins <= 5'h01;
    repeat (10) @(posedge clock);
    aux_pins <= 5'h00;
    rdchk(8'h20, 32'hc);
    bus(1'b1, 8'h00, 32'h1d);
    repeat (3) @(posedge clock);
    check("abort", move_abort, 1'b1);
    follow(2, 0);
    bus(1'b1, 8'h00, 32'h10);
    repeat (3) @(posedge clock);
    check("abort", move_abort, 1'b0);
    bus(1'b1, 8'h00, 32'h11);
    aux_pins <= 5'h08;
    repeat (10) @(posedge clock);
    check("abort", move_abort, 1'b1);
    aux_pins <= 5'h00;
    bus(1'b1, 8'h00, 32'h90);
    bus(1'b1, 8'h14, 32'h8);
    bus(1'b1, 8'h00, 32'h11);
    check("abort", move_abort, 1'b0);
    aux_pins <= 5'h02;
    repeat (10) @(posedge clock);
    check("abort", move_abort, 1'b1);
    aux_pins <= 5'h00;
    bus(1'b1, 8'h00, 32'h90);
    bus(1'b1, 8'h00, 32'h30);
    bus(1'b0, 8'h00, 32'h0);
    check("gear and stall", rd[5:4], 2'b01);
    bus(1'b1, 8'h0c, 32'hc8);
    bus(1'b1, 8'h00, 32'h41);
    repeat (60) @(posedge clock);
    check("hybrid", hybrid_active, 1'b1);
    bus(1'b1, 8'h00, 32'h0);
    repeat (3) @(posedge clock);
    check("hybrid", hybrid_active, 1'b0);
    bus(1'b1, 8'h00, 32'h61);
    move_step <= 1'b1;
    repeat (40) @(posedge clock);
    move_step <= 1'b0;
    bus(1'b0, 8'h18, 32'h0);
    check("stall status", rd[5:2], 4'b1001);
    check("abort", move_abort, 1'b1);
    bus(1'b1, 8'h00, 32'h1);
    bus(1'b1, 8'h0c, 32'h10);
    bus(1'b0, 8'h18, 32'h0);
    check("lag", rd[3], 1'b1);
    check("hybrid", hybrid_active, 1'b1);
    conclude();
  end
endmodule
bind efs_gearing efs_gearing_assertions chk_u (.clock, .sys_rst, .aux_pins, .step_out,
  .dir_cw, .move_abort, .moving, .hybrid_active, .current_pct, .loop_gain);
`default_nettype wire
